// file: ssb_pkg.sv
package ssb_pkg;
  // Register byte offsets on the Wishbone word bus
  localparam int ADR_W = 5;
  localparam logic [4:0] OFS_STATUS = 5'h00;
  localparam logic [4:0] OFS_BAUD = 5'h04;
  localparam logic [4:0] OFS_MODE = 5'h08;
  localparam logic [4:0] OFS_CTRL = 5'h0c;
  localparam logic [4:0] OFS_TXDATA = 5'h10;
  localparam logic [4:0] OFS_RXDATA = 5'h14;
  localparam logic [4:0] OFS_IRQ_ST = 5'h18;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h1c;

  // Status register fields
  localparam int ST_TX_EMPTY = 7;
  localparam int ST_RX_FULL = 6;
  localparam int ST_PARITY_ERR = 3;
  localparam int ST_TX_DONE = 2;
  localparam int ST_RSV_RX = 1;
  localparam int ST_RSV_TX = 0;
  localparam logic [7:0] STATUS_RESET = 8'h84;

  // Mode and control fields
  localparam int MODE_SYNC = 7;
  localparam int MODE_CKS_HI = 1;
  localparam int MODE_CKS_LO = 0;
  localparam int CTRL_TX_EN = 5;
  localparam int CTRL_RX_EN = 4;

  // Interrupt status and mask fields
  localparam int IRQ_PARITY = 0;
  localparam int IRQ_TX_DONE = 1;
  localparam int IRQ_RX_FULL = 2;
  localparam int IRQ_TX_EMPTY = 3;
  localparam int IRQ_W = 4;

  localparam logic [7:0] BAUD_RESET = 8'hff;

  // Clock-select encodings and prescale terminal counts
  localparam logic [1:0] CKS_SYS = 2'h0;
  localparam logic [1:0] CKS_WATCH = 2'h1;
  localparam logic [1:0] CKS_DIV16 = 2'h2;
  localparam logic [1:0] CKS_DIV64 = 2'h3;
  localparam logic [5:0] DIV16_LAST = 6'h0f;
  localparam logic [5:0] DIV64_LAST = 6'h3f;
  // Samples per bit: 32 asynchronous, 8 clocked synchronous
  localparam logic [4:0] ASYNC_BIT_LAST = 5'h1f;
  localparam logic [4:0] SYNC_BIT_LAST = 5'h07;
endpackage

// file: ssb_sync2.sv
`timescale 1ns/10ps
`default_nettype none
module ssb_sync2 (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_async,
  output logic o_sync
);
  logic meta;
  logic next_meta;
  logic next_sync;

  always_comb begin
    next_meta = i_async;
    next_sync = meta;
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      meta <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta <= next_meta;
      o_sync <= next_sync;
    end
  end
endmodule // ssb_sync2
`default_nettype wire

// file: ssb_tick_div.sv
`timescale 1ns/10ps
`default_nettype none
module ssb_tick_div #(
  parameter int WIDTH = 8
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_tick,
  input wire logic [WIDTH-1:0] i_last,
  output logic o_tick
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic wrap;

  // Counts input ticks 0..i_last, pulsing on the wrap
  always_comb begin
    wrap = i_tick && (count >= i_last);
    next_count = count;
    if (wrap) begin
      next_count = '0;
    end else if (i_tick) begin
      next_count = count + WIDTH'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      count <= '0;
      o_tick <= 1'b0;
    end else begin
      count <= next_count;
      o_tick <= wrap;
    end
  end
endmodule // ssb_tick_div
`default_nettype wire

// file: ssb_top.sv
// Implementation choices: the register addresses and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
module ssb_top (
  input wire logic I_CLK_SYS,
  input wire logic I_RESETN,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [4:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  input wire logic I_LOW_POWER,
  input wire logic I_WATCH_CLK,
  input wire logic I_RX_CHAR_VALID,
  input wire logic [7:0] I_RX_CHAR,
  input wire logic I_RX_PARITY_BAD,
  input wire logic I_TX_LOAD,
  input wire logic I_TX_LAST_BIT,
  output logic [7:0] O_TX_DATA,
  output logic O_TX_DATA_VALID,
  output logic O_TX_ALLOW,
  output logic O_RX_ALLOW,
  output logic O_SYNC_MODE,
  output logic O_SAMPLE_TICK,
  output logic O_BIT_TICK,
  output logic O_IRQ
);
  // Bus access state
  logic acc;
  logic wr;
  logic rd;
  logic [31:0] next_rdata;
  logic next_ack;

  // Software registers
  logic [7:0] baud_divider;
  logic [7:0] next_baud_divider;
  logic [7:0] serial_mode_reg;
  logic [7:0] next_serial_mode_reg;
  logic [7:0] serial_control_reg;
  logic [7:0] next_serial_control_reg;
  logic [7:0] tx_data_reg;
  logic [7:0] next_tx_data_reg;
  logic [7:0] rx_data_reg;
  logic [7:0] next_rx_data_reg;
  logic tx_pending;
  logic next_tx_pending;

  // Status flags and their read-as-one arming bits
  logic parity_err_flag;
  logic next_parity_err_flag;
  logic tx_done_flag;
  logic next_tx_done_flag;
  logic tx_empty_flag;
  logic next_tx_empty_flag;
  logic rx_full_flag;
  logic next_rx_full_flag;
  logic reserved_tx_bit;
  logic next_reserved_tx_bit;
  logic parity_armed;
  logic next_parity_armed;
  logic tx_empty_armed;
  logic next_tx_empty_armed;
  logic rx_full_armed;
  logic next_rx_full_armed;
  logic [7:0] status_view;

  // Interrupts
  logic [ssb_pkg::IRQ_W-1:0] irq_status;
  logic [ssb_pkg::IRQ_W-1:0] next_irq_status;
  logic [ssb_pkg::IRQ_W-1:0] irq_mask;
  logic [ssb_pkg::IRQ_W-1:0] next_irq_mask;
  logic [ssb_pkg::IRQ_W-1:0] irq_event;

  // Baud generation
  logic watch_sync;
  logic watch_prev;
  logic watch_edge;
  logic div16_tick;
  logic div64_tick;
  logic src_tick;
  logic sample_tick;
  logic bit_tick;
  logic [4:0] bit_last;

  // Event decode from the shifters
  logic sync_mode;
  logic tx_en;
  logic rx_en;
  logic rx_take;
  logic rx_good;
  logic rx_bad;
  logic tx_last_set;
  logic tx_load_take;

  // Status and data register access decode
  logic st_wr;
  logic clr_parity;
  logic clr_tx_empty;
  logic clr_rx_full;
  logic st_rd;
  logic tx_wr;
  logic rx_rd;

  assign acc = I_WB_CYC && I_WB_STB && O_WB_ACK;
  assign wr = acc && I_WB_WE && I_WB_SEL[0];
  assign rd = acc && !I_WB_WE;

  assign sync_mode = serial_mode_reg[ssb_pkg::MODE_SYNC];
  assign tx_en = serial_control_reg[ssb_pkg::CTRL_TX_EN];
  assign rx_en = serial_control_reg[ssb_pkg::CTRL_RX_EN];

  assign O_RX_ALLOW = rx_en && !parity_err_flag;
  assign O_TX_ALLOW = tx_en && !(sync_mode && parity_err_flag);
  assign O_SYNC_MODE = sync_mode;
  assign O_TX_DATA = tx_data_reg;
  assign O_TX_DATA_VALID = tx_pending;

  // Characters arriving while the gate is shut are dropped here as well
  assign rx_take = I_RX_CHAR_VALID && O_RX_ALLOW;
  assign rx_good = rx_take && !I_RX_PARITY_BAD;
  assign rx_bad = rx_take && I_RX_PARITY_BAD;
  assign tx_load_take = I_TX_LOAD && tx_pending && O_TX_ALLOW;
  assign tx_last_set = I_TX_LAST_BIT && tx_empty_flag;

  assign st_wr = wr && (I_WB_ADR == ssb_pkg::OFS_STATUS);
  assign st_rd = rd && (I_WB_ADR == ssb_pkg::OFS_STATUS);
  assign tx_wr = wr && (I_WB_ADR == ssb_pkg::OFS_TXDATA);
  assign rx_rd = rd && (I_WB_ADR == ssb_pkg::OFS_RXDATA);
  assign clr_parity = st_wr && !I_WB_DAT[ssb_pkg::ST_PARITY_ERR] && parity_armed;
  assign clr_tx_empty = st_wr && !I_WB_DAT[ssb_pkg::ST_TX_EMPTY] && tx_empty_armed;
  assign clr_rx_full = st_wr && !I_WB_DAT[ssb_pkg::ST_RX_FULL] && rx_full_armed;

  always_comb begin
    status_view = '0;
    status_view[ssb_pkg::ST_TX_EMPTY] = tx_empty_flag;
    status_view[ssb_pkg::ST_RX_FULL] = rx_full_flag;
    status_view[ssb_pkg::ST_PARITY_ERR] = parity_err_flag;
    status_view[ssb_pkg::ST_TX_DONE] = tx_done_flag;
    status_view[ssb_pkg::ST_RSV_RX] = 1'b0;
    status_view[ssb_pkg::ST_RSV_TX] = reserved_tx_bit;
  end

  // Bus slave: ack one cycle after the request, read data captured with it
  always_comb begin
    next_ack = I_WB_CYC && I_WB_STB && !O_WB_ACK;
    next_rdata = '0;
    unique case (I_WB_ADR)
      ssb_pkg::OFS_STATUS: next_rdata[7:0] = status_view;
      ssb_pkg::OFS_BAUD: next_rdata[7:0] = baud_divider;
      ssb_pkg::OFS_MODE: next_rdata[7:0] = serial_mode_reg;
      ssb_pkg::OFS_CTRL: next_rdata[7:0] = serial_control_reg;
      ssb_pkg::OFS_TXDATA: next_rdata[7:0] = tx_data_reg;
      ssb_pkg::OFS_RXDATA: next_rdata[7:0] = rx_data_reg;
      ssb_pkg::OFS_IRQ_ST: next_rdata[ssb_pkg::IRQ_W-1:0] = irq_status;
      ssb_pkg::OFS_IRQ_MASK: next_rdata[ssb_pkg::IRQ_W-1:0] = irq_mask;
      default: next_rdata = '0;
    endcase
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RESETN) begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= '0;
    end else begin
      O_WB_ACK <= next_ack;
      O_WB_DAT <= next_rdata;
    end
  end

  // Plain software registers and the data path
  always_comb begin
    next_baud_divider = baud_divider;
    next_serial_mode_reg = serial_mode_reg;
    next_serial_control_reg = serial_control_reg;
    next_tx_data_reg = tx_data_reg;
    next_rx_data_reg = rx_data_reg;
    next_tx_pending = tx_pending;
    next_reserved_tx_bit = reserved_tx_bit;
    if (wr && I_WB_ADR == ssb_pkg::OFS_BAUD) begin
      next_baud_divider = I_WB_DAT[7:0];
    end
    if (I_LOW_POWER) begin
      next_baud_divider = ssb_pkg::BAUD_RESET;
    end
    if (wr && I_WB_ADR == ssb_pkg::OFS_MODE) begin
      next_serial_mode_reg = I_WB_DAT[7:0];
    end
    if (wr && I_WB_ADR == ssb_pkg::OFS_CTRL) begin
      next_serial_control_reg = I_WB_DAT[7:0];
    end
    if (st_wr) begin
      next_reserved_tx_bit = I_WB_DAT[ssb_pkg::ST_RSV_TX];
    end
    if (tx_load_take) begin
      next_tx_pending = 1'b0;
    end
    if (tx_wr) begin
      next_tx_data_reg = I_WB_DAT[7:0];
      next_tx_pending = 1'b1;
    end
    if (rx_take) begin
      next_rx_data_reg = I_RX_CHAR;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RESETN) begin
      baud_divider <= ssb_pkg::BAUD_RESET;
      serial_mode_reg <= '0;
      serial_control_reg <= '0;
      tx_data_reg <= '0;
      rx_data_reg <= '0;
      tx_pending <= 1'b0;
      reserved_tx_bit <= 1'b0;
    end else begin
      baud_divider <= next_baud_divider;
      serial_mode_reg <= next_serial_mode_reg;
      serial_control_reg <= next_serial_control_reg;
      tx_data_reg <= next_tx_data_reg;
      rx_data_reg <= next_rx_data_reg;
      tx_pending <= next_tx_pending;
      reserved_tx_bit <= next_reserved_tx_bit;
    end
  end

  // Status flags; in every flag a set beats a same-cycle clear
  always_comb begin
    next_parity_armed = parity_armed;
    next_tx_empty_armed = tx_empty_armed;
    next_rx_full_armed = rx_full_armed;
    if (st_rd) begin
      next_parity_armed = parity_err_flag;
      next_tx_empty_armed = tx_empty_flag;
      next_rx_full_armed = rx_full_flag;
    end
    // A clear consumes its arming read
    if (clr_parity) begin
      next_parity_armed = 1'b0;
    end
    if (clr_tx_empty) begin
      next_tx_empty_armed = 1'b0;
    end
    if (clr_rx_full || rx_rd) begin
      next_rx_full_armed = 1'b0;
    end

    next_parity_err_flag = parity_err_flag;
    if (clr_parity) begin
      next_parity_err_flag = 1'b0;
    end
    if (rx_bad) begin
      next_parity_err_flag = 1'b1;
    end

    next_rx_full_flag = rx_full_flag;
    if (clr_rx_full || rx_rd) begin
      next_rx_full_flag = 1'b0;
    end
    if (rx_good) begin
      next_rx_full_flag = 1'b1;
    end

    next_tx_empty_flag = tx_empty_flag;
    if (clr_tx_empty || tx_wr) begin
      next_tx_empty_flag = 1'b0;
    end
    if (tx_load_take || !tx_en) begin
      next_tx_empty_flag = 1'b1;
    end

    next_tx_done_flag = tx_done_flag;
    if (clr_tx_empty || tx_wr) begin
      next_tx_done_flag = 1'b0;
    end
    if (tx_last_set || !tx_en) begin
      next_tx_done_flag = 1'b1;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RESETN) begin
      parity_err_flag <= ssb_pkg::STATUS_RESET[ssb_pkg::ST_PARITY_ERR];
      tx_done_flag <= ssb_pkg::STATUS_RESET[ssb_pkg::ST_TX_DONE];
      tx_empty_flag <= ssb_pkg::STATUS_RESET[ssb_pkg::ST_TX_EMPTY];
      rx_full_flag <= ssb_pkg::STATUS_RESET[ssb_pkg::ST_RX_FULL];
      parity_armed <= 1'b0;
      tx_empty_armed <= 1'b0;
      rx_full_armed <= 1'b0;
    end else begin
      parity_err_flag <= next_parity_err_flag;
      tx_done_flag <= next_tx_done_flag;
      tx_empty_flag <= next_tx_empty_flag;
      rx_full_flag <= next_rx_full_flag;
      parity_armed <= next_parity_armed;
      tx_empty_armed <= next_tx_empty_armed;
      rx_full_armed <= next_rx_full_armed;
    end
  end

  // Interrupts: sticky on flag rising, write one to clear, set wins
  always_comb begin
    irq_event = '0;
    irq_event[ssb_pkg::IRQ_PARITY] = next_parity_err_flag && !parity_err_flag;
    irq_event[ssb_pkg::IRQ_TX_DONE] = next_tx_done_flag && !tx_done_flag;
    irq_event[ssb_pkg::IRQ_RX_FULL] = next_rx_full_flag && !rx_full_flag;
    irq_event[ssb_pkg::IRQ_TX_EMPTY] = next_tx_empty_flag && !tx_empty_flag;
    next_irq_status = irq_status;
    next_irq_mask = irq_mask;
    if (wr && I_WB_ADR == ssb_pkg::OFS_IRQ_ST) begin
      next_irq_status = irq_status & ~I_WB_DAT[ssb_pkg::IRQ_W-1:0];
    end
    next_irq_status = next_irq_status | irq_event;
    if (wr && I_WB_ADR == ssb_pkg::OFS_IRQ_MASK) begin
      next_irq_mask = I_WB_DAT[ssb_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RESETN) begin
      irq_status <= '0;
      irq_mask <= '0;
      O_IRQ <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      O_IRQ <= |(next_irq_status & next_irq_mask);
    end
  end

  // Watch clock is a slow foreign pin; only its rising edges are counted
  ssb_sync2 u_watch_sync (
    .i_clk(I_CLK_SYS),
    .i_resetn(I_RESETN),
    .i_async(I_WATCH_CLK),
    .o_sync(watch_sync)
  );

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RESETN) begin
      watch_prev <= 1'b0;
    end else begin
      watch_prev <= watch_sync;
    end
  end

  assign watch_edge = watch_sync && !watch_prev;

  ssb_tick_div #(.WIDTH(6)) u_div16 (
    .i_clk(I_CLK_SYS),
    .i_resetn(I_RESETN),
    .i_tick(1'b1),
    .i_last(ssb_pkg::DIV16_LAST),
    .o_tick(div16_tick)
  );

  ssb_tick_div #(.WIDTH(6)) u_div64 (
    .i_clk(I_CLK_SYS),
    .i_resetn(I_RESETN),
    .i_tick(1'b1),
    .i_last(ssb_pkg::DIV64_LAST),
    .o_tick(div64_tick)
  );

  always_comb begin
    unique case (serial_mode_reg[ssb_pkg::MODE_CKS_HI:ssb_pkg::MODE_CKS_LO])
      ssb_pkg::CKS_SYS: src_tick = 1'b1;
      ssb_pkg::CKS_WATCH: src_tick = watch_edge;
      ssb_pkg::CKS_DIV16: src_tick = div16_tick;
      ssb_pkg::CKS_DIV64: src_tick = div64_tick;
    endcase
  end

  ssb_tick_div #(.WIDTH(8)) u_baud_div (
    .i_clk(I_CLK_SYS),
    .i_resetn(I_RESETN),
    .i_tick(src_tick),
    .i_last(baud_divider),
    .o_tick(sample_tick)
  );

  assign bit_last = sync_mode ? ssb_pkg::SYNC_BIT_LAST : ssb_pkg::ASYNC_BIT_LAST;

  ssb_tick_div #(.WIDTH(5)) u_bit_div (
    .i_clk(I_CLK_SYS),
    .i_resetn(I_RESETN),
    .i_tick(sample_tick),
    .i_last(bit_last),
    .o_tick(bit_tick)
  );

  assign O_SAMPLE_TICK = sample_tick;
  assign O_BIT_TICK = bit_tick;
endmodule // ssb_top
`default_nettype wire

// file: ssb_shifter_model.sv
`timescale 1ns/10ps
`default_nettype none
module ssb_shifter_model (
  input wire logic i_clk,
  input wire logic i_tx_valid,
  input wire logic i_tx_allow,
  input wire logic [3:0] i_delay,
  output logic o_rx_valid,
  output logic [7:0] o_rx_char,
  output logic o_rx_bad,
  output logic o_tx_load,
  output logic o_tx_last
);
  logic [4:0] cnt;
  logic busy;

  initial begin
    o_rx_valid = 1'b0;
    o_rx_char = 8'h00;
    o_rx_bad = 1'b0;
    o_tx_load = 1'b0;
    o_tx_last = 1'b0;
    cnt = 5'h00;
    busy = 1'b0;
  end

  // Lines show the inverse of the last value between characters, never a stale copy
  task send_char(input logic [7:0] d, input logic bad);
    @(posedge i_clk);
    o_rx_valid <= 1'b1;
    o_rx_char <= d;
    o_rx_bad <= bad;
    @(posedge i_clk);
    o_rx_valid <= 1'b0;
    o_rx_char <= ~d;
    o_rx_bad <= ~bad;
  endtask

  // Slow or prompt pickup, then a fixed character length before the last bit
  always @(posedge i_clk) begin
    o_tx_load <= 1'b0;
    o_tx_last <= 1'b0;
    if (!busy && i_tx_valid && i_tx_allow) begin
      cnt <= cnt + 5'h01;
      if (cnt >= {1'b0, i_delay}) begin
        o_tx_load <= 1'b1;
        busy <= 1'b1;
        cnt <= 5'h00;
      end
    end else if (busy) begin
      cnt <= cnt + 5'h01;
      if (cnt == 5'h0a) begin
        o_tx_last <= 1'b1;
        busy <= 1'b0;
        cnt <= 5'h00;
      end
    end
  end
endmodule // ssb_shifter_model
`default_nettype wire

// file: ssb_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module ssb_monitor (
  input wire logic I_CLK_SYS,
  input wire logic I_RESETN,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [4:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  input wire logic O_WB_ACK,
  input wire logic I_RX_CHAR_VALID,
  input wire logic I_RX_PARITY_BAD,
  input wire logic I_TX_LOAD,
  input wire logic [7:0] O_TX_DATA,
  input wire logic O_TX_DATA_VALID,
  input wire logic O_TX_ALLOW,
  input wire logic O_RX_ALLOW,
  input wire logic O_SYNC_MODE,
  input wire logic O_BIT_TICK
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RESETN);
  logic tx_wr;
  logic bad_rx;
  assign tx_wr = I_WB_CYC && I_WB_STB && O_WB_ACK && I_WB_WE && I_WB_SEL[0]
    && (I_WB_ADR == ssb_pkg::OFS_TXDATA);
  assign bad_rx = I_RX_CHAR_VALID && I_RX_PARITY_BAD && O_RX_ALLOW;

  AST_ACK_NEXT: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK) // bus
    else $error("ack not in second cycle");
  AST_ACK_PULSE: assert property (O_WB_ACK |=> !O_WB_ACK) // bus
    else $error("ack longer than one cycle");
  AST_PER_BLOCKS_RX: assert property (bad_rx |=> !O_RX_ALLOW[*2]) // rx stop
    else $error("receiver still open after parity error");
  AST_SYNC_BLOCKS_TX: assert property (bad_rx && O_SYNC_MODE |=> !O_TX_ALLOW) // sync
    else $error("transmit still open after sync parity error");
  AST_BIT_GAP: assert property (O_BIT_TICK |=> !O_BIT_TICK[*7]) // bit rate
    else $error("bit ticks too close");
  AST_TX_WRITE: assert property (tx_wr |=> O_TX_DATA_VALID // data write
    && (O_TX_DATA == $past(I_WB_DAT[7:0])))
    else $error("transmit data write not taken");
  AST_TX_TAKE: assert property (I_TX_LOAD && O_TX_DATA_VALID && O_TX_ALLOW // empty again
    && !tx_wr |=> !O_TX_DATA_VALID)
    else $error("pending data not released on load");
  AST_RESET_QUIET: assert property ($rose(I_RESETN) |-> !O_TX_ALLOW && !O_TX_DATA_VALID)
    else $error("transmit side active out of reset");

  COV_PARITY_SYNC: cover property (bad_rx && O_SYNC_MODE);
  COV_TX_LOAD: cover property (I_TX_LOAD && O_TX_DATA_VALID && O_TX_ALLOW);
  COV_BIT_TICK: cover property (O_BIT_TICK);
endmodule // ssb_monitor
bind ssb_top ssb_monitor u_mon (
  .I_CLK_SYS(I_CLK_SYS),
  .I_RESETN(I_RESETN),
  .I_WB_CYC(I_WB_CYC),
  .I_WB_STB(I_WB_STB),
  .I_WB_WE(I_WB_WE),
  .I_WB_ADR(I_WB_ADR),
  .I_WB_SEL(I_WB_SEL),
  .I_WB_DAT(I_WB_DAT),
  .O_WB_ACK(O_WB_ACK),
  .I_RX_CHAR_VALID(I_RX_CHAR_VALID),
  .I_RX_PARITY_BAD(I_RX_PARITY_BAD),
  .I_TX_LOAD(I_TX_LOAD),
  .O_TX_DATA(O_TX_DATA),
  .O_TX_DATA_VALID(O_TX_DATA_VALID),
  .O_TX_ALLOW(O_TX_ALLOW),
  .O_RX_ALLOW(O_RX_ALLOW),
  .O_SYNC_MODE(O_SYNC_MODE),
  .O_BIT_TICK(O_BIT_TICK)
);
`default_nettype wire

// file: tb_serial_status_and_bitrate.sv
`timescale 1ns/10ps
`default_nettype none
module tb_serial_status_and_bitrate;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic lp = 1'b0;
  logic wclk = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [3:0] sel = 4'hf;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack, rxv, rxb, txl, txlast, txv, txa, rxa, syncm, stick, btick, irq;
  logic [7:0] rxc, txd, q, d;
  logic [3:0] dly = 4'h0;
  logic [15:0] lfsr = 16'h4c1b;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  int n;

  always #4 clk = ~clk;
  // Watch source free-running and unrelated in phase
  always #37 wclk = ~wclk;

  ssb_top DUT (.I_CLK_SYS(clk), .I_RESETN(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat),
    .O_WB_ACK(ack), .I_LOW_POWER(lp), .I_WATCH_CLK(wclk), .I_RX_CHAR_VALID(rxv),
    .I_RX_CHAR(rxc), .I_RX_PARITY_BAD(rxb), .I_TX_LOAD(txl), .I_TX_LAST_BIT(txlast),
    .O_TX_DATA(txd), .O_TX_DATA_VALID(txv), .O_TX_ALLOW(txa), .O_RX_ALLOW(rxa),
    .O_SYNC_MODE(syncm), .O_SAMPLE_TICK(stick), .O_BIT_TICK(btick), .O_IRQ(irq));

  ssb_shifter_model u_far (.i_clk(clk), .i_tx_valid(txv), .i_tx_allow(txa), .i_delay(dly),
    .o_rx_valid(rxv), .o_rx_char(rxc), .o_rx_bad(rxb), .o_tx_load(txl), .o_tx_last(txlast));

  function logic [15:0] next_rand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function int exp_gap(input int c, input int nn);
    return (c == 2 ? 16 : (c == 3 ? 64 : 1)) * (nn + 1);
  endfunction

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task end_of_test;
    if (num_errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Request held until the rising edge that samples ack high; data taken there
  task wb(input logic w, input logic [4:0] a, input logic [7:0] v, input logic [3:0] s);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= {24'h0, v};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task wr(input logic [4:0] a, input logic [7:0] v);
    wb(1'b1, a, v, 4'hf);
  endtask

  task rd(input logic [4:0] a);
    wb(1'b0, a, 8'h00, 4'hf);
  endtask

  task rs;
    rd(ssb_pkg::OFS_STATUS);
  endtask

  task gap(input logic b, output int g);
    do @(negedge clk); while ((b ? btick : stick) !== 1'b1);
    g = 0;
    do begin
      @(negedge clk);
      g++;
    end while ((b ? btick : stick) !== 1'b1 && g < 300);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      end_of_test;
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rs;
    chk(q, 8'h84);
    rd(ssb_pkg::OFS_BAUD);
    chk(q, 8'hff);
    rd(5'h02);
    chk(q, 8'h00);
    wr(ssb_pkg::OFS_STATUS, 8'hfe);
    rs;
    chk(q, 8'h84);
    for (int i = 0; i < 6; i++) begin
      lfsr = next_rand(lfsr);
      d = (i == 0) ? 8'h00 : lfsr[7:0];
      wr(ssb_pkg::OFS_BAUD, d);
      rd(ssb_pkg::OFS_BAUD);
      chk(q, d);
    end
    // Byte lane off: the write must not land
    wb(1'b1, ssb_pkg::OFS_BAUD, ~d, 4'he);
    rd(ssb_pkg::OFS_BAUD);
    chk(q, d);
    @(posedge clk);
    lp <= 1'b1;
    @(posedge clk);
    lp <= 1'b0;
    rd(ssb_pkg::OFS_BAUD);
    chk(q, 8'hff);
    wr(ssb_pkg::OFS_CTRL, 8'h30);
    for (int c = 0; c < 4; c++) begin
      lfsr = next_rand(lfsr);
      d = {6'h00, lfsr[1:0]};
      wr(ssb_pkg::OFS_BAUD, d);
      wr(ssb_pkg::OFS_MODE, 8'(c));
      gap(1'b0, n);
      gap(1'b0, n);
      if (c != 1) chk(n, exp_gap(c, int'(d)));
      // Synchronised watch edges land 9 or 10 system cycles apart
      if (c == 1) chk(n >= 9 * (int'(d) + 1) && n <= 10 * (int'(d) + 1), 1'b1);
    end
    wr(ssb_pkg::OFS_BAUD, 8'h00);
    wr(ssb_pkg::OFS_MODE, 8'h00);
    gap(1'b1, n);
    gap(1'b1, n);
    chk(n, 32);
    wr(ssb_pkg::OFS_MODE, 8'h80);
    gap(1'b1, n);
    gap(1'b1, n);
    chk(n, 8);
    chk(syncm, 1'b1);
    wr(ssb_pkg::OFS_MODE, 8'h00);
    lfsr = next_rand(lfsr);
    d = lfsr[7:0];
    u_far.send_char(d, 1'b1);
    rs;
    chk(q, 8'h8c);
    rd(ssb_pkg::OFS_RXDATA);
    chk(q, d);
    chk(irq, 1'b0);
    u_far.send_char(~d, 1'b0);
    rd(ssb_pkg::OFS_RXDATA);
    chk(q, d);
    wr(ssb_pkg::OFS_CTRL, 8'h20);
    rs;
    chk(q, 8'h8c);
    wr(ssb_pkg::OFS_IRQ_MASK, 8'h01);
    wr(ssb_pkg::OFS_STATUS, 8'h8c);
    rs;
    chk(q, 8'h8c);
    chk(irq, 1'b1);
    wr(ssb_pkg::OFS_IRQ_ST, 8'h01);
    // parity flag cleared by writing 0 to its bit after a status read showed it as 1
    wr(ssb_pkg::OFS_STATUS, 8'h80);
    rs;
    chk(q, 8'h84);
    chk(irq, 1'b0);
    wr(ssb_pkg::OFS_CTRL, 8'h30);
    wr(ssb_pkg::OFS_MODE, 8'h80);
    u_far.send_char(lfsr[7:0], 1'b1);
    @(negedge clk);
    chk({txa, rxa}, 2'b00);
    rs;
    wr(ssb_pkg::OFS_STATUS, 8'h80);
    @(negedge clk);
    chk({txa, rxa}, 2'b11);
    d = ~d;
    u_far.send_char(d, 1'b0);
    rs;
    chk(q[6], 1'b1);
    rd(ssb_pkg::OFS_RXDATA);
    chk(q, d);
    rs;
    chk(q[6], 1'b0);
    wr(ssb_pkg::OFS_MODE, 8'h00);
    for (int i = 0; i < 2; i++) begin
      lfsr = next_rand(lfsr);
      dly <= (i == 0) ? 4'h0 : 4'hf;
      d = lfsr[7:0];
      wr(ssb_pkg::OFS_TXDATA, d);
      rs;
      chk(q[2], 1'b0);
      chk(txd, d);
      n = 0;
      do begin
        rs;
        n++;
      end while (q[2] !== 1'b1 && n < 40);
      chk(q & 8'h84, 8'h84);
    end
    wr(ssb_pkg::OFS_STATUS, 8'h00);
    rs;
    chk(q & 8'h84, 8'h00);
    wr(ssb_pkg::OFS_CTRL, 8'h10);
    rs;
    chk(q[2], 1'b1);
    end_of_test;
  end
endmodule // tb_serial_status_and_bitrate
`default_nettype wire
